/* rtl/fdm_top.sv */
/*
  Holds the drive and motor control register, the diagnostic status
  register and the drive type register of the floppy controller, with the
  decode of select and motor pins and the DMA gate.
  Assumes an ISA style I/O bus with active-low chip select, read and write
  strobes held for several clock cycles, mode straps from configuration
  logic on this clock, and write gate and write data from the command engine
  on this clock. Read data comes from the drive pin.
*/
`default_nettype none
`include "fdm_defines.svh"

module fdm_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out_ff,
  output logic data_oe_n_ff,
  input wire logic fdc_enable,
  input wire logic four_drive,
  input wire logic alt_mode,
  input wire logic enh_tdr,
  input wire logic [3:0] drive_id,
  input wire logic write_gate_n,
  input wire logic wdata_n,
  input wire logic rdata_n,
  output logic drive_sel_pin_lo,
  output logic drive_sel_pin_hi,
  output logic motor_zero_n,
  output logic motor_one_n,
  output logic ctrl_soft_reset_ff,
  output logic dma_enable_ff
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [14:0] bus_s;
  logic cs_n_s;
  logic ior_n_s;
  logic iow_n_s;
  logic [2:0] addr_s;
  logic [7:0] data_s;
  logic rdata_n_s;

  // Bus strobes, address, data and the read data pin cross on two stages.
  fdm_sync #(
    .W(15),
    .INIT(15'h7800)
  ) u_bus_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din({rdata_n, cs_n, ior_n, iow_n, addr, data_in}),
    .dout(bus_s)
  );

  // Unpacks the synchronised group.
  assign rdata_n_s = bus_s[14];
  assign cs_n_s = bus_s[13];
  assign ior_n_s = bus_s[12];
  assign iow_n_s = bus_s[11];
  assign addr_s = bus_s[10:8];
  assign data_s = bus_s[7:0];

  // ************************************************************
  // Bus phase tracking
  // ************************************************************
  fdm_pkg::fdm_bus_t bus_ff;
  fdm_pkg::fdm_bus_t nxt_bus;
  logic [2:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic wr_commit;

  // Steps between idle, write and read as the strobes come and go.
  always_comb
  begin
    nxt_bus = bus_ff;
    unique case (bus_ff)
      fdm_pkg::FDM_BUS_IDLE:
      begin
        if (!cs_n_s && !iow_n_s)
          nxt_bus = fdm_pkg::FDM_BUS_WR;
        else if (!cs_n_s && !ior_n_s)
          nxt_bus = fdm_pkg::FDM_BUS_RD;
      end
      fdm_pkg::FDM_BUS_WR:
      begin
        if (iow_n_s)
          nxt_bus = fdm_pkg::FDM_BUS_IDLE;
      end
      fdm_pkg::FDM_BUS_RD:
      begin
        if (ior_n_s)
          nxt_bus = fdm_pkg::FDM_BUS_IDLE;
      end
      default:
        nxt_bus = fdm_pkg::FDM_BUS_IDLE;
    endcase
  end

  // Holds the bus phase.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      bus_ff <= fdm_pkg::FDM_BUS_IDLE;
    else
      bus_ff <= nxt_bus;
  end

  // Captures address at the start of a write and data through its end.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_addr_ff <= 3'h0;
      wr_data_ff <= 8'h00;
    end
    else
    begin
      if (bus_ff == fdm_pkg::FDM_BUS_IDLE)
        wr_addr_ff <= addr_s;
      if (!iow_n_s)
        wr_data_ff <= data_s;
    end
  end

  // A write lands on the trailing edge of the strobe.
  assign wr_commit = (bus_ff == fdm_pkg::FDM_BUS_WR) && iow_n_s;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] dor_ff;
  logic [3:0] tdr_ff;

  // write any time
  // Soft reset never touches this register, only the hardware reset.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      dor_ff <= `FDM_DOR_RST;
    else if (wr_commit && wr_addr_ff == `FDM_OFF_DOR)
      dor_ff <= wr_data_ff;
  end

  // drive type storage
  // Exchange bits are writable only in enhanced drive type mode.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tdr_ff <= `FDM_TDR_RST;
    else if (wr_commit && wr_addr_ff == `FDM_OFF_TDR)
    begin
      tdr_ff[1:0] <= wr_data_ff[1:0];
      if (enh_tdr)
        tdr_ff[3:2] <= wr_data_ff[3:2];
    end
  end

  // ************************************************************
  // Drive and motor decode
  // ************************************************************
  logic [1:0] sel;
  logic [1:0] xchg;
  logic [1:0] phys_sel;
  logic [1:0] log_of0;
  logic [1:0] log_of1;
  logic [3:0] mot;
  logic wr_pulse;
  logic nxt_sel_lo;
  logic nxt_sel_hi;
  logic nxt_mot0_n;
  logic nxt_mot1_n;

  // Maps a drive number through the exchange; each swap is its own inverse.
  function automatic logic [1:0] fdm_map(input logic [1:0] d, input logic [1:0] x);
    logic [1:0] r;
    r = d;
    if (x == `FDM_XCHG_01 && d[1] == 1'b0)
      r = {1'b0, ~d[0]};
    else if (x == `FDM_XCHG_02 && d[0] == 1'b0)
      r = {~d[1], 1'b0};
    return r;
  endfunction

  assign sel = dor_ff[`FDM_DOR_SEL1:`FDM_DOR_SEL0];
  assign mot = dor_ff[`FDM_DOR_MOT+3:`FDM_DOR_MOT];
  assign xchg = (four_drive || !enh_tdr) ? `FDM_XCHG_NONE : tdr_ff[3:2];
  assign phys_sel = fdm_map(sel, xchg);
  assign log_of0 = fdm_map(2'h0, xchg);
  assign log_of1 = fdm_map(2'h1, xchg);
  assign wr_pulse = (bus_ff == fdm_pkg::FDM_BUS_WR) && !iow_n_s && wr_addr_ff == `FDM_OFF_DOR;

  // Works out the next level of every drive and motor pin.
  always_comb
  begin
    nxt_sel_lo = 1'b1;
    nxt_sel_hi = 1'b1;
    nxt_mot0_n = 1'b1;
    nxt_mot1_n = 1'b1;
    if (fdc_enable && four_drive)
    begin
      nxt_sel_lo = sel[0];
      nxt_sel_hi = sel[1];
      nxt_mot0_n = ~mot[sel];
      nxt_mot1_n = wr_pulse; // High only while a control write is held.
    end
    else if (fdc_enable)
    begin
      nxt_sel_lo = (phys_sel != 2'h0);
      nxt_sel_hi = (phys_sel != 2'h1);
      nxt_mot0_n = ~mot[log_of0];
      nxt_mot1_n = ~mot[log_of1];
    end
  end

  // Drives the pins from flip-flops; all inactive through reset.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      drive_sel_pin_lo <= 1'b1;
      drive_sel_pin_hi <= 1'b1;
      motor_zero_n <= 1'b1;
      motor_one_n <= 1'b1;
    end
    else
    begin
      drive_sel_pin_lo <= nxt_sel_lo;
      drive_sel_pin_hi <= nxt_sel_hi;
      motor_zero_n <= nxt_mot0_n;
      motor_one_n <= nxt_mot1_n;
    end
  end

  // ************************************************************
  // Soft reset and DMA gate
  // ************************************************************
  // soft reset level
  // The command engine reloads its parameters while this is high.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_soft_reset_ff <= 1'b1;
    else
      ctrl_soft_reset_ff <= ~dor_ff[`FDM_DOR_NRST];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      dma_enable_ff <= 1'b0;
    else
      dma_enable_ff <= alt_mode | dor_ff[`FDM_DOR_DMA];
  end

  // ************************************************************
  // Diagnostic status
  // ************************************************************
  logic write_gate_n_ff;
  logic rdata_par;
  logic wdata_par;
  logic [7:0] diag_status_b;
  logic [7:0] tdr_rd;
  logic [1:0] id_sel;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      write_gate_n_ff <= 1'b0;
    else
      write_gate_n_ff <= ~write_gate_n;
  end

  fdm_parity u_rdata_par (
    .clk(clk),
    .rst_b(rst_b),
    .sig_n(rdata_n_s),
    .parity_ff(rdata_par)
  );

  fdm_parity u_wdata_par (
    .clk(clk),
    .rst_b(rst_b),
    .sig_n(wdata_n),
    .parity_ff(wdata_par)
  );

  // Assembles the status byte from live state.
  always_comb
  begin
    diag_status_b = 8'h00;
    diag_status_b[7:6] = `FDM_TOP_ONES;
    diag_status_b[`FDM_SRB_DSEL] = dor_ff[`FDM_DOR_SEL0];
    diag_status_b[`FDM_SRB_WDATA] = wdata_par;
    diag_status_b[`FDM_SRB_RDATA] = rdata_par;
    diag_status_b[`FDM_SRB_WRITE_GATE_N] = write_gate_n_ff;
    diag_status_b[`FDM_SRB_MOT1] = ~motor_one_n;
    diag_status_b[`FDM_SRB_MOT0] = ~motor_zero_n;
  end

  // Drive identity follows the selected drive zero or one.
  assign id_sel = (sel == 2'h0) ? drive_id[1:0] : ((sel == 2'h1) ? drive_id[3:2] : 2'h0);
  assign tdr_rd = enh_tdr ? {`FDM_TOP_ONES, id_sel, tdr_ff} : {6'h00, tdr_ff[1:0]};

  // ************************************************************
  // Read data path
  // ************************************************************
  // Presents the control or drive type register, or in alternate mode the status register, while a read strobe is held.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_out_ff <= 8'h00;
      data_oe_n_ff <= 1'b1;
    end
    else if (nxt_bus == fdm_pkg::FDM_BUS_RD && bus_ff == fdm_pkg::FDM_BUS_IDLE)
    begin
      data_oe_n_ff <= 1'b1;
      unique case (addr_s)
        `FDM_OFF_DOR:
        begin
          data_out_ff <= dor_ff;
          data_oe_n_ff <= 1'b0;
        end
        `FDM_OFF_TDR:
        begin
          data_out_ff <= tdr_rd;
          data_oe_n_ff <= 1'b0;
        end
        `FDM_OFF_SRB:
        begin
          data_out_ff <= diag_status_b;
          data_oe_n_ff <= ~alt_mode;
        end
        default:
          data_out_ff <= 8'h00;
      endcase
    end
    else if (nxt_bus != fdm_pkg::FDM_BUS_RD)
      data_oe_n_ff <= 1'b1;
  end

endmodule

`default_nettype wire

/* shared/fdm_defines.svh */
/*
  Holds the offsets, field positions, reset values and fixed read patterns of
  the drive and motor control block.
  Assumes it is included by its bare name from every file that needs it.
*/
`ifndef FDM_DEFINES_SVH
`define FDM_DEFINES_SVH

`define FDM_ADDR_W 3
`define FDM_OFF_SRB 3'h1
`define FDM_OFF_DOR 3'h2
`define FDM_OFF_TDR 3'h3
`define FDM_DOR_RST 8'h00
`define FDM_TDR_RST 4'h0
`define FDM_DOR_SEL0 0
`define FDM_DOR_SEL1 1
`define FDM_DOR_NRST 2
`define FDM_DOR_DMA 3
`define FDM_DOR_MOT 4
`define FDM_SRB_MOT0 0
`define FDM_SRB_MOT1 1
`define FDM_SRB_WRITE_GATE_N 2
`define FDM_SRB_RDATA 3
`define FDM_SRB_WDATA 4
`define FDM_SRB_DSEL 5
`define FDM_TOP_ONES 2'h3
`define FDM_XCHG_NONE 2'h0
`define FDM_XCHG_01 2'h1
`define FDM_XCHG_02 2'h2

`endif

/* shared/fdm_pkg.sv */
/*
  Holds the types shared by the drive and motor control block.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
`default_nettype none

package fdm_pkg;

  // Host bus access phase; idle to write and idle to read each flip one bit.
  typedef enum logic [1:0]
  {
    FDM_BUS_IDLE = 2'h0,
    FDM_BUS_WR = 2'h1,
    FDM_BUS_RD = 2'h2
  } fdm_bus_t;

endpackage

`default_nettype wire

/* rtl/fdm_sync.sv */
/*
  Holds a two flip-flop synchroniser for a group of pin inputs.
  Assumes each bit is a level from outside the clock domain.
*/
`default_nettype none

module fdm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_ff;

  // ************************************************************
  // Per-bit two stage synchroniser
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      // The first stage is read only by the second.
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_ff[gi] <= INIT[gi];
          dout[gi] <= INIT[gi];
        end
        else
        begin
          meta_ff[gi] <= din[gi];
          dout[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* rtl/fdm_parity.sv */
/*
  Holds a parity flag that changes state on each rising edge of a signal.
  Assumes the input is already in the clock domain and active low, so the
  rising edge is its inactive edge.
*/
`default_nettype none

module fdm_parity (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sig_n,
  output logic parity_ff
);

  logic prev_ff;

  // Remembers the last level to find the inactive edge.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      prev_ff <= 1'b1;
    else
      prev_ff <= sig_n;
  end

  // Flips the flag on each low to high transition; hardware reset clears it.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      parity_ff <= 1'b0;
    else if (sig_n && !prev_ff)
      parity_ff <= ~parity_ff;
  end

endmodule

`default_nettype wire

/* verification/fdm_top_chk.sv */
/*
  Port checker of the drive and motor control block.
  Assumes mode straps only change while rst_b is low.
*/
`default_nettype none

module fdm_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_n,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_out_ff,
  input wire logic data_oe_n_ff,
  input wire logic fdc_enable,
  input wire logic four_drive,
  input wire logic alt_mode,
  input wire logic write_gate_n,
  input wire logic drive_sel_pin_lo,
  input wire logic drive_sel_pin_hi,
  input wire logic motor_zero_n,
  input wire logic motor_one_n,
  input wire logic ctrl_soft_reset_ff,
  input wire logic dma_enable_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Ages of the last write, write to 2, read
  // ****************************************
  logic [3:0] wr_age_ff;
  logic [3:0] w2_age_ff;
  logic [3:0] rd_age_ff;
  logic [3:0] pins;
  assign pins = {drive_sel_pin_lo, drive_sel_pin_hi, motor_zero_n, motor_one_n};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Each age restarts while its strobe is low and saturates at 15.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) wr_age_ff <= 4'hf;
    else if (!iow_n && !cs_n) wr_age_ff <= 4'h0;
    else if (wr_age_ff != 4'hf) wr_age_ff <= wr_age_ff + 4'h1;
  end

  // The write-to-2 age feeds the motor-one pulse bound.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) w2_age_ff <= 4'hf;
    else if (!iow_n && !cs_n && addr == 3'h2) w2_age_ff <= 4'h0;
    else if (w2_age_ff != 4'hf) w2_age_ff <= w2_age_ff + 4'h1;
  end

  // The read age bounds how long read data is driven.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) rd_age_ff <= 4'hf;
    else if (!ior_n && !cs_n) rd_age_ff <= 4'h0;
    else if (rd_age_ff != 4'hf) rd_age_ff <= rd_age_ff + 4'h1;
  end

  a_top_ones: assert property (
    $fell(data_oe_n_ff) && addr == 3'h1 |-> data_out_ff[7:6] == 2'h3)
    else $error("status top bits not ones");
  a_write_gate_n_mirror: assert property (
    $fell(data_oe_n_ff) && addr == 3'h1 && $stable(write_gate_n)
    && $past(write_gate_n, 3) == write_gate_n |-> data_out_ff[2] == !write_gate_n)
    else $error("write gate status wrong");
  a_read_offsets: assert property (
    $fell(data_oe_n_ff) |-> addr inside {3'h2, 3'h3} || (addr == 3'h1 && alt_mode))
    else $error("read data driven for a refused offset");
  a_read_span: assert property (!data_oe_n_ff |-> rd_age_ff <= 4'h5)
    else $error("read data driven too long");
  a_dma_alt: assert property (alt_mode && $past(rst_b) |-> dma_enable_ff)
    else $error("dma gate off in alternate mode");
  a_dma_write: assert property (
    !alt_mode && $changed(dma_enable_ff) |-> wr_age_ff inside {[4'h1:4'h8]})
    else $error("dma gate moved without a write");
  a_srst_write: assert property (
    $changed(ctrl_soft_reset_ff) |-> wr_age_ff inside {[4'h1:4'h8]})
    else $error("soft reset moved without a write");
  a_pulse_span: assert property (
    fdc_enable && four_drive && motor_one_n && $past(rst_b) |-> w2_age_ff <= 4'h5)
    else $error("motor one high outside a write pulse");
  a_off_pins: assert property (!fdc_enable && $past(rst_b) |-> pins == 4'hf)
    else $error("pins active while disabled");
  a_one_select: assert property (
    !four_drive |-> drive_sel_pin_lo || drive_sel_pin_hi)
    else $error("two selects active");
  a_pins_write: assert property (
    !four_drive && $past(rst_b, 2) && $changed(pins) |-> wr_age_ff inside {[4'h1:4'h8]})
    else $error("pins moved without a write");

  c_pulse: cover property (four_drive && motor_one_n);
  c_status: cover property ($fell(data_oe_n_ff) && addr == 3'h1);
  c_release: cover property ($fell(ctrl_soft_reset_ff));
endmodule

bind fdm_top fdm_chk u_fdm_chk (.clk, .rst_b, .cs_n, .ior_n, .iow_n, .addr,
  .data_out_ff, .data_oe_n_ff, .fdc_enable, .four_drive, .alt_mode, .write_gate_n,
  .drive_sel_pin_lo, .drive_sel_pin_hi, .motor_zero_n, .motor_one_n,
  .ctrl_soft_reset_ff, .dma_enable_ff);

`default_nettype wire

/* verification/fdm_host_model.sv */
/*
  Host model that runs single I/O read and write cycles.
  Assumes one caller at a time, entered just after a rising edge.
*/
`default_nettype none

module fdm_host_model (
  input wire logic clk,
  input wire logic [7:0] data_out_ff,
  input wire logic data_oe_n_ff,
  output logic cs_n,
  output logic ior_n,
  output logic iow_n,
  output logic [2:0] addr,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Bus cycle
  // ****************************************
  // Idle bus at time zero.
  initial
  begin
    cs_n = 1'b1;
    ior_n = 1'b1;
    iow_n = 1'b1;
    addr = 3'h0;
    data_in = 8'h5a;
  end

  // Strobe held six edges; released lines show inverted values.
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic drv);
    q = 8'h00;
    drv = 1'b0;
    @(posedge clk);
    cs_n <= 1'b0;
    addr <= a;
    data_in <= d;
    iow_n <= !wr;
    ior_n <= wr;
    repeat (6)
    begin
      @(posedge clk);
      if (data_oe_n_ff === 1'b0)
      begin
        q = data_out_ff;
        drv = 1'b1;
      end
    end
    cs_n <= 1'b1;
    ior_n <= 1'b1;
    iow_n <= 1'b1;
    addr <= ~a;
    data_in <= ~d;
    repeat (7) @(posedge clk);
  endtask
endmodule

`default_nettype wire

/* verification/tb_fdm_top.sv */
/*
  Self-checking bench of the drive and motor control block.
  Assumes the host model and the bound port checker.
*/
`default_nettype none

module tb_fdm_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic fdc_enable = 1'b1;
  logic four_drive = 1'b0;
  logic alt_mode = 1'b0;
  logic enh_tdr = 1'b0;
  logic write_gate_n = 1'b1;
  logic wdata_n = 1'b1;
  logic rdata_n = 1'b1;
  logic [3:0] drive_id = 4'h9;
  logic cs_n, ior_n, iow_n, data_oe_n_ff, drive_sel_pin_lo, drive_sel_pin_hi;
  logic motor_zero_n, motor_one_n, ctrl_soft_reset_ff, dma_enable_ff, drv;
  int pulses = 0;
  logic [2:0] addr;
  logic [7:0] data_in, data_out_ff, q, v;
  logic [3:0] e;
  logic [7:0] tbl [8] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
  int mismatches = 0;
  int checked = 0;
  int seed = 32'h52bc;
  int rp, wp;

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  fdm_top u_fdm_top (.clk, .rst_b, .cs_n, .ior_n, .iow_n, .addr, .data_in,
    .data_out_ff, .data_oe_n_ff, .fdc_enable, .four_drive, .alt_mode, .enh_tdr,
    .drive_id, .write_gate_n, .wdata_n, .rdata_n, .drive_sel_pin_lo,
    .drive_sel_pin_hi, .motor_zero_n, .motor_one_n, .ctrl_soft_reset_ff,
    .dma_enable_ff);
  fdm_host_model u_fdm_host_model (.clk, .data_out_ff, .data_oe_n_ff, .cs_n,
    .ior_n, .iow_n, .addr, .data_in);

  // Counts the cycles with motor one high in four-drive mode.
  always @(posedge clk)
    if (motor_one_n && four_drive && rst_b) pulses <= pulses + 1;

  // Physical drive that a logical drive lands on.
  function automatic logic [1:0] map(input logic [1:0] s, input logic [1:0] xc);
    if (xc == 2'h1 && !s[1]) return s ^ 2'h1;
    if (xc == 2'h2 && !s[0]) return s ^ 2'h2;
    return s;
  endfunction

  // Expected {sel_lo, sel_hi, motor0, motor1} pins.
  function automatic logic [3:0] exp_pins(input logic [7:0] c, input logic [1:0] xc);
    logic [1:0] p;
    p = map(c[1:0], xc);
    if (four_drive) return {c[0], c[1], !c[4 + c[1:0]], 1'b0};
    return {p != 2'h0, p != 2'h1, !c[4 + map(2'h0, xc)], !c[4 + map(2'h1, xc)]};
  endfunction

  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_fdm_host_model.access(1'b1, a, d, q, drv);
  endtask

  task automatic rd(input logic [2:0] a);
    u_fdm_host_model.access(1'b0, a, 8'h00, q, drv);
  endtask

  task automatic pins(input logic [3:0] x);
    chk({4'h0, drive_sel_pin_lo, drive_sel_pin_hi, motor_zero_n, motor_one_n}, {4'h0, x});
  endtask

  // Straps change only under a ten-cycle hardware reset.
  task automatic mode(input logic en, input logic fd, input logic am, input logic et);
    @(posedge clk);
    rst_b <= 1'b0;
    fdc_enable <= en;
    four_drive <= fd;
    alt_mode <= am;
    enh_tdr <= et;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // One low pulse on write data or read data.
  task automatic blip(input logic w);
    wdata_n <= !w;
    rdata_n <= w;
    repeat (2) @(posedge clk);
    wdata_n <= 1'b1;
    rdata_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // Main sequence: AT, alternate, four-drive, exchange, disabled.
  initial
  begin
    mode(1'b1, 1'b0, 1'b0, 1'b0);
    rd(3'h2);
    chk(q, 8'h00);
    chk({7'h0, ctrl_soft_reset_ff}, 8'h01);
    rd(3'h1);
    chk({7'h0, drv}, 8'h00);
    repeat (24)
    begin
      v = 8'($random(seed));
      wr(3'h2, v);
      rd(3'h2);
      chk(q, v);
      chk({7'h0, ctrl_soft_reset_ff}, {7'h0, !v[2]});
      chk({7'h0, dma_enable_ff}, {7'h0, v[3]});
      pins(exp_pins(v, 2'h0));
    end
    wr(3'h2, 8'h1c);
    wr(3'h2, 8'h18);
    chk({7'h0, ctrl_soft_reset_ff}, 8'h01);
    wr(3'h2, 8'h1c);
    chk({7'h0, ctrl_soft_reset_ff}, 8'h00);
    pins(exp_pins(8'h1c, 2'h0));
    mode(1'b1, 1'b0, 1'b1, 1'b0);
    rd(3'h2);
    chk(q, 8'h00);
    rp = 0;
    wp = 0;
    repeat (8)
    begin
      v = 8'($random(seed));
      write_gate_n <= v[7];
      wr(3'h2, v);
      repeat (v[5:4])
      begin
        blip(1'b0);
        rp++;
      end
      repeat (v[1:0])
      begin
        blip(1'b1);
        wp++;
      end
      e = exp_pins(v, 2'h0);
      rd(3'h1);
      chk(q, {2'h3, v[0], wp[0], rp[0], !v[7], !e[0], !e[1]});
      chk({7'h0, dma_enable_ff}, 8'h01);
    end
    mode(1'b1, 1'b1, 1'b0, 1'b1);
    wr(3'h3, 8'h04);
    for (int k = 0; k < 8; k++)
    begin
      rp = pulses;
      wr(3'h2, tbl[k]);
      chk({7'h0, (pulses - rp) inside {[1:8]}}, 8'h01);
      pins(exp_pins(tbl[k], 2'h0));
    end
    mode(1'b1, 1'b0, 1'b0, 1'b1);
    v = 8'($random(seed));
    drive_id <= v[3:0];
    wr(3'h2, 8'h1c);
    rd(3'h3);
    chk(q, {2'h3, drive_id[1:0], 4'h0});
    for (int x = 1; x < 3; x++)
    begin
      wr(3'h3, {4'h0, x[1:0], 2'h0});
      for (int k = 0; k < 4; k++)
      begin
        wr(3'h2, tbl[k]);
        pins(exp_pins(tbl[k], x[1:0]));
      end
    end
    rd(3'h3);
    chk(q, 8'hc8);
    mode(1'b0, 1'b0, 1'b0, 1'b0);
    wr(3'h2, 8'h1c);
    pins(4'hf);
    close_out;
  end

  // Watchdog against a hung run.
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out;
  end
endmodule

`default_nettype wire
